/* File: src/sbsc_defines.svh */
// Purpose: Constants for the burst SRAM cycle control block
// Assumes: Included by bare name from the package and modules
// Notes:   Definitions only
`ifndef SBSC_DEFINES_SVH
`define SBSC_DEFINES_SVH

// Cycle type encodings
`define SBSC_CYC_IDLE    2'h0
`define SBSC_CYC_BEGIN   2'h1
`define SBSC_CYC_NEXT    2'h2
`define SBSC_CYC_HOLD    2'h3

// Burst counter step and reset values
`define SBSC_CNT_STEP    2'h1
`define SBSC_CNT_RST     2'h0

`endif

/* File: src/sbsc_pkg.sv */
// Purpose: Shared types for the burst SRAM cycle control block
// Assumes: Constants come from sbsc_defines.svh
// Notes:   Types only
`include "sbsc_defines.svh"

package sbsc_pkg;

  // *****************************
  // Cycle types
  // *****************************
  typedef enum logic [1:0] {
    SBSC_IDLE  = 2'b00,  // Deselect
    SBSC_BEGIN = 2'b01,  // Begin burst at external address
    SBSC_NEXT  = 2'b10,  // Continue burst
    SBSC_HOLD  = 2'b11   // Suspend burst
  } sbsc_cycle_type;

endpackage : sbsc_pkg

/* File: src/sbsc_burst_counter.sv */
// Purpose: Two-bit burst address counter, linear or interleaved order
// Assumes: Synchronous to sys_clk
// Notes:   Preset on burst start, steps on continue
`timescale 1ns/100ps
`include "sbsc_defines.svh"

module sbsc_burst_counter (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       load,
  input  wire logic       step,
  input  wire logic [1:0] start_low,
  input  wire logic       sequential_order_select,
  // Result
  output logic      [1:0] burst_low
);

  logic [1:0] start_ff;  // Preset low address bits
  logic [1:0] count_ff;  // Steps taken since preset
  logic [1:0] eff_count; // Count in use this cycle

  // *****************************
  // Counter state
  // *****************************
  // Preset on load, step modulo four
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      start_ff <= `SBSC_CNT_RST;
      count_ff <= `SBSC_CNT_RST;
    end else if (load) begin
      start_ff <= start_low;
      count_ff <= `SBSC_CNT_RST;
    end else if (step) begin
      count_ff <= count_ff + `SBSC_CNT_STEP;
    end
  end

  // Linear adds, interleaved xors; low select means linear
  // A continue uses the stepped count in the same cycle
  always_comb begin
    eff_count = (step && !load) ? count_ff + `SBSC_CNT_STEP : count_ff;
    if (!sequential_order_select) begin
      burst_low = start_ff + eff_count;
    end else begin
      burst_low = start_ff ^ eff_count;
    end
  end

  // Fifth address of a run equals the first
  wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && !load) [*5] |-> (burst_low == $past(burst_low, 4)))
    else $error("burst counter did not wrap after four steps");

endmodule : sbsc_burst_counter

/* File: src/sbsc_cycle_control.sv */
// Purpose: Cycle decode, burst addressing and data pipeline of a sync burst SRAM
// Assumes: Inputs synchronous to sys_clk; output enable applied combinationally
// Notes:   Small internal array stands in for the storage core
`timescale 1ns/100ps
`include "sbsc_defines.svh"

module sbsc_cycle_control #(
  parameter int ADDR_W = 8,   // Word address width
  parameter int LANES  = 4,   // Byte lanes
  parameter int LANE_W = 9    // Bits per lane
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  // Selects and strobes
  input  wire logic                      primary_select_low,
  input  wire logic                      secondary_select_high,
  input  wire logic                      secondary_select_low,
  input  wire logic                      proc_addr_strobe,
  input  wire logic                      ctrl_addr_strobe,
  input  wire logic                      burst_step_enable,
  // Write controls
  input  wire logic                      all_lane_store,
  input  wire logic                      lane_store_enable,
  input  wire logic [LANES-1:0]          lane_store_select,
  // Modes
  input  wire logic                      sequential_order_select,
  input  wire logic                      output_enable_low,
  // Address and data
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [LANES*LANE_W-1:0]   dq_in,
  output logic      [LANES*LANE_W-1:0]   dq_out,
  output logic      [LANES*LANE_W-1:0]   dq_oe_low,
  // Status
  output sbsc_pkg::sbsc_cycle_type       cycle_kind
);

  localparam int DEPTH = 1 << ADDR_W;  // Words in storage
  localparam int DW    = LANES * LANE_W;

  logic [DW-1:0]           mem [DEPTH];  // Storage core
  logic [ADDR_W-3:0]       upper_ff;     // Registered upper address
  logic [1:0]              burst_low;    // Counter output
  logic                    active_ff;    // Burst active (not deselected)
  logic [DW-1:0]           rdata_ff;     // Read output register
  logic                    rdrv_ff;      // Read data staged for drive
  logic                    chip_ok;      // Secondary selects true
  logic                    qual_write;   // Qualified write
  logic                    deselect;     // Deselect decoded
  logic                    start;        // Burst start decoded
  logic                    step;         // Continue decoded
  logic [ADDR_W-1:0]       cur_addr;     // Address used this cycle
  logic [LANES-1:0]        lane_wr;      // Lanes written
  sbsc_pkg::sbsc_cycle_type nxt_kind;    // Decoded cycle type

  // *****************************
  // Cycle decode
  // *****************************
  assign chip_ok    = secondary_select_high && !secondary_select_low;
  assign qual_write = !all_lane_store || (!lane_store_enable && !(&lane_store_select));
  assign deselect   = (primary_select_low && !ctrl_addr_strobe)
                    || (!primary_select_low && !chip_ok
                        && (!proc_addr_strobe || !ctrl_addr_strobe));
  assign start      = !primary_select_low && chip_ok
                    && (!proc_addr_strobe || !ctrl_addr_strobe);
  // No strobe taken and advance low: continue
  assign step       = !deselect && !start && !burst_step_enable;

  // Cycle type selection
  always_comb begin
    if (deselect) begin
      nxt_kind = sbsc_pkg::SBSC_IDLE;
    end else if (start) begin
      nxt_kind = sbsc_pkg::SBSC_BEGIN;
    end else if (!burst_step_enable) begin
      nxt_kind = sbsc_pkg::SBSC_NEXT;
    end else begin
      nxt_kind = sbsc_pkg::SBSC_HOLD;
    end
  end
  assign cycle_kind = nxt_kind;

  // Write only when processor strobe not starting a read
  logic active_or_start;  // Cycle touches the array
  logic do_write;         // Write performed this cycle
  assign active_or_start = start || active_ff;
  assign do_write = qual_write && !deselect && active_or_start
                    && !(start && !proc_addr_strobe);

  // *****************************
  // Burst address
  // *****************************
  sbsc_burst_counter u_counter (
    .sys_clk                 (sys_clk),
    .sys_rst                 (sys_rst),
    .load                    (start),
    .step                    (step && active_ff),
    .start_low               (addr[1:0]),
    .sequential_order_select (sequential_order_select),
    .burst_low               (burst_low)
  );

  // Upper address register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      upper_ff <= '0;
    end else if (start) begin
      upper_ff <= addr[ADDR_W-1:2];
    end
  end

  // External address on start, else counter; a continue already sees the next address
  always_comb begin
    if (start) begin
      cur_addr = addr;
    end else begin
      cur_addr = {upper_ff, burst_low};
    end
  end

  // Burst activity
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      active_ff <= 1'b0;
    end else if (deselect) begin
      active_ff <= 1'b0;
    end else if (start) begin
      active_ff <= 1'b1;
    end
  end

  // *****************************
  // Storage writes
  // *****************************
  always_comb begin
    if (!all_lane_store) begin
      lane_wr = '1;
    end else begin
      lane_wr = ~lane_store_select;
    end
  end

  // Write selected lanes only
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (do_write && lane_wr[i]) begin
        mem[cur_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
      end
    end
  end

  // *****************************
  // Read pipeline
  // *****************************
  // Data registered on the same edge that samples the cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (active_or_start && !deselect && !do_write) begin
      rdata_ff <= mem[cur_addr];
    end
  end

  // Drive stage: cleared at once by deselect or write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdrv_ff <= 1'b0;
    end else begin
      rdrv_ff <= active_or_start && !deselect && !do_write;
    end
  end

  assign dq_out    = rdata_ff;
  // Enable low drives; output enable high forces off
  assign dq_oe_low = {DW{!(rdrv_ff && !output_enable_low)}};

  // *****************************
  // Checks
  // *****************************
  oe_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    output_enable_low |-> (&dq_oe_low))
    else $error("drivers on with output enable high");

  desel_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    deselect |=> (&dq_oe_low))
    else $error("drivers on after deselect");

  write_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    do_write |=> (&dq_oe_low))
    else $error("drivers on after write");

  read_data_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (start && !proc_addr_strobe && !output_enable_low) ##1 !output_enable_low |-> !dq_oe_low[0])
    else $error("read data not driven one clock later");

  desel_dec_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (primary_select_low && !ctrl_addr_strobe) |-> cycle_kind == sbsc_pkg::SBSC_IDLE)
    else $error("deselect not decoded");

  proc_ign_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (primary_select_low && ctrl_addr_strobe) |-> cycle_kind != sbsc_pkg::SBSC_BEGIN)
    else $error("processor strobe taken while primary high");

  suspend_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cycle_kind == sbsc_pkg::SBSC_HOLD && active_ff) ##1 (cycle_kind == sbsc_pkg::SBSC_HOLD)
      |-> $stable(burst_low))
    else $error("suspend moved burst address");

  preset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    start ##1 !step |-> burst_low == $past(addr[1:0]) && upper_ff == $past(addr[ADDR_W-1:2]))
    else $error("burst preset wrong");

  lane_q_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!all_lane_store) |-> qual_write)
    else $error("global write not qualified");

endmodule : sbsc_cycle_control

/* File: test/sbsc_ctrl_model.sv */
// Purpose: Controller model driving the synchronous SRAM bus
// Assumes: Bench changes commands just after a rising edge
// Notes:   Released data bus shows the inverse of its last value
`timescale 1ns/100ps
module sbsc_ctrl_model (
  // Clock and command
  input  wire logic        sys_clk,
  input  wire logic [2:0]  op,
  input  wire logic [1:0]  wm,
  input  wire logic [1:0]  rnd,
  input  wire logic [3:0]  lanes,
  input  wire logic [35:0] wdata,
  // Bus pins
  output logic             primary_select_low,
  output logic             secondary_select_high,
  output logic             secondary_select_low,
  output logic             proc_addr_strobe,
  output logic             ctrl_addr_strobe,
  output logic             burst_step_enable,
  output logic             all_lane_store,
  output logic             lane_store_enable,
  output logic      [3:0]  lane_store_select,
  output logic      [35:0] dq_in
);
  logic [35:0] last_ff = '0;  // Last data bus value
  // ****************
  // Command to pins
  // ****************
  always_comb begin
    primary_select_low    = (op == 3'h0) || ((op > 3'h4) && rnd[1]);
    secondary_select_high = (op != 3'h1) || rnd[1];
    secondary_select_low  = (op == 3'h1);
    proc_addr_strobe      = (op > 3'h4) ? (!rnd[1] || rnd[0]) : (op == 3'h2) ? 1'b0 : (op > 3'h1) || rnd[0];
    ctrl_addr_strobe      = (op == 3'h2) ? rnd[0] : (op > 3'h4);
    burst_step_enable     = (op == 3'h6) || ((op != 3'h5) && rnd[0]);
    all_lane_store        = (wm != 2'h2);
    lane_store_enable     = (wm == 2'h1) ? 1'b0 : rnd[0];
    lane_store_select     = (wm == 2'h0) ? 4'hf : ~lanes;
    dq_in                 = (wm == 2'h0) ? ~last_ff : wdata;
  end
  // Remember the bus for the released pattern
  always_ff @(posedge sys_clk) begin
    last_ff <= dq_in;
  end
endmodule : sbsc_ctrl_model

/* File: test/sync_burst_sram_cycle_control_tb.sv */
// Purpose: Self-checking bench for the burst SRAM cycle control
// Assumes: Controller model turns bench commands into pins
// Notes:   Reference memory and burst counter live in the bench
`timescale 1ns/100ps
module sync_burst_sram_cycle_control_tb;
  // ****************
  // Signals
  // ****************
  logic sys_clk = 1'b0, sys_rst = 1'b1, sequential_order_select = 1'b0, output_enable_low = 1'b0;
  logic [2:0] op = 3'h1;
  logic [1:0] wm = 2'h0, rnd = 2'h0;
  logic [3:0] lanes = 4'h1, lane_store_select;
  logic [7:0] addr = 8'h00, base = 8'h00;
  logic [35:0] wdata = '0, dq_in, dq_out, dq_oe_low, exp_now;
  logic [35:0] mem [256];
  logic primary_select_low, secondary_select_high, secondary_select_low, proc_addr_strobe, ctrl_addr_strobe;
  logic burst_step_enable, all_lane_store, lane_store_enable;
  logic val_now = 1'b0, active = 1'b0;
  logic [1:0] cnt = 2'h0;
  logic [31:0] seed = 32'h0000_ba9b;
  int mismatches = 0, checks_done = 0;
  sbsc_pkg::sbsc_cycle_type cycle_kind;

  always #12.5 sys_clk = ~sys_clk;

  sbsc_ctrl_model ctrl (.sys_clk, .op, .wm, .rnd, .lanes, .wdata, .primary_select_low, .secondary_select_high,
    .secondary_select_low, .proc_addr_strobe, .ctrl_addr_strobe, .burst_step_enable, .all_lane_store,
    .lane_store_enable, .lane_store_select, .dq_in);
  sbsc_cycle_control uut (.sys_clk, .sys_rst, .primary_select_low, .secondary_select_high, .secondary_select_low,
    .proc_addr_strobe, .ctrl_addr_strobe, .burst_step_enable, .all_lane_store, .lane_store_enable,
    .lane_store_select, .sequential_order_select, .output_enable_low, .addr, .dq_in, .dq_out, .dq_oe_low,
    .cycle_kind);

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic sbsc_pkg::sbsc_cycle_type kexp(input logic [2:0] o);
    return (o < 3'h2) ? sbsc_pkg::SBSC_IDLE : (o < 3'h5) ? sbsc_pkg::SBSC_BEGIN :
           (o == 3'h5) ? sbsc_pkg::SBSC_NEXT : sbsc_pkg::SBSC_HOLD;
  endfunction : kexp
  task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_kind(input sbsc_pkg::sbsc_cycle_type got, input sbsc_pkg::sbsc_cycle_type exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_kind
  // Reference burst counter and memory at each edge
  task automatic sample();
    logic [7:0] a;
    val_now = 1'b0;
    if (sys_rst || op < 3'h2) active = 1'b0;
    else if (op < 3'h5) begin
      active = 1'b1;
      base = addr;
      cnt = 2'h0;
    end else if (op == 3'h5) cnt = cnt + 2'h1;
    a = {base[7:2], sequential_order_select ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (active && (op == 3'h2 || wm == 2'h0)) begin
      val_now = 1'b1;
      exp_now = mem[a];
    end else if (active) begin
      for (int i = 0; i < 4; i++) if (wm == 2'h2 || lanes[i]) mem[a][i*9 +: 9] = wdata[i*9 +: 9];
    end
  endtask : sample
  // One bus cycle; w of 3 picks the write kind at random
  task automatic cyc(input logic [2:0] o, input logic [7:0] a, input logic [1:0] w);
    logic [31:0] r;
    logic [1:0] wv;
    seed = lfsr(seed);
    r = seed;
    wv = (w == 2'h3) ? (r[9] ? 2'h2 : {1'b0, r[8]}) : w;
    if (o == 3'h3) wv = 2'h0;
    if (o == 3'h4 && wv == 2'h0) wv = 2'h1;
    @(posedge sys_clk);
    sample();
    op <= o;
    addr <= a;
    wm <= wv;
    rnd <= r[11:10];
    wdata <= {r[3:0], r};
    lanes <= (r[7:4] == 4'h0) ? 4'h8 : r[7:4];
    output_enable_low <= r[12] & r[13];
    @(negedge sys_clk);
    chk_kind(cycle_kind, kexp(o));
    chk_data(dq_oe_low, {36{~(val_now & ~output_enable_low)}});
    if (val_now) chk_data(dq_out, exp_now);
    if (val_now && !output_enable_low && r[14]) begin
      output_enable_low = 1'b1;
      #1 chk_data(dq_oe_low, '1);
      output_enable_low = 1'b0;
    end
  endtask : cyc

  // ****************
  // Run control
  // ****************
  task automatic results();
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    #(25 * 5000);
    mismatches++;
    results();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    chk_data(dq_out, '0);
    cyc(3'h5, 8'h00, 2'h0);
    cyc(3'h6, 8'h00, 2'h1);
    for (int a = 0; a < 256; a++) cyc(3'h4, a[7:0], 2'h2);
    for (int m = 0; m < 2; m++) begin
      sequential_order_select <= m[0];
      cyc(3'h1, 8'h00, 2'h0);
      cyc(3'h3, 8'h4e, 2'h0);
      repeat (5) cyc(3'h5, 8'h00, 2'h0);
      cyc(3'h4, 8'h91, 2'h1);
      cyc(3'h6, 8'h00, 2'h1);
      cyc(3'h5, 8'h00, 2'h1);
      cyc(3'h2, 8'h91, 2'h3);
      repeat (3) cyc(3'h5, 8'h00, 2'h0);
      repeat (800) begin
        seed = lfsr(seed);
        cyc((seed[2:0] == 3'h7) ? 3'h5 : seed[2:0], seed[15:8], 2'h3);
      end
    end
    cyc(3'h0, 8'h00, 2'h0);
    results();
  end
endmodule : sync_burst_sram_cycle_control_tb
